//--- ddrmpr_ctl_model.sv
// controller model on the command port
module ddrmpr_ctl_model (
  input wire logic                mclk,
  output ddrmpr_pkg::ddrmpr_req_t req
);
  timeunit 1ns / 1ps;
  import ddrmpr_pkg::*;
  initial req = '0;
  // only mrs and reads, banks idle, dll locked
  task automatic send(ddrmpr_cmd_t c, logic [ADDR_W-1:0] a);
    req = '{1'b1, c, MR3_SEL, a};
    @(posedge mclk);
    #1;
    req.valid = 1'b0;
    req.addr = ~a;
  endtask
endmodule // ddrmpr_ctl_model

//--- ddrmpr_pkg.sv
// package: constants and carrier types for the calibration-register readout block
package ddrmpr_pkg;

  localparam int unsigned BA_W          = 3;
  localparam int unsigned ADDR_W        = 14;
  localparam int unsigned LANE_W        = 8;
  localparam int unsigned BURST_LEN     = 8;
  localparam int unsigned CHOP_LEN      = 4;
  localparam int unsigned BEAT_W        = 3;
  localparam int unsigned READ_LATENCY  = 6;
  localparam int unsigned LAT_W         = 4;

  // mode register 3 field positions
  localparam logic [BA_W-1:0] MR3_SEL   = 3'h3;
  localparam int unsigned MR3_EN_BIT    = 2;
  localparam int unsigned MR3_LOC_LSB   = 0;
  localparam int unsigned MR3_LOC_MSB   = 1;
  // read address bits
  localparam int unsigned RD_HALF_BIT   = 2;
  localparam int unsigned RD_CHOP_BIT   = 12;

  localparam logic [1:0] LOC_PATTERN    = 2'h0;
  // beat order 0..7, bit 0 is first beat: alternating 0,1,0,1,...
  localparam logic [BURST_LEN-1:0] CAL_PATTERN = 8'hAA;
  localparam logic [BEAT_W-1:0] HALF_START     = 3'h4;
  localparam logic [BEAT_W-1:0] BEAT_ZERO      = 3'h0;
  localparam logic [LAT_W-1:0]  LAT_ZERO       = 4'h0;

  typedef enum logic [2:0] {
    DDRMPR_CMD_NOP,
    DDRMPR_CMD_MRS,
    DDRMPR_CMD_RD,
    DDRMPR_CMD_RDA,
    DDRMPR_CMD_WR,
    DDRMPR_CMD_OTHER
  } ddrmpr_cmd_t;

  typedef struct packed {
    logic              valid;
    ddrmpr_cmd_t       cmd;
    logic [BA_W-1:0]   bank;
    logic [ADDR_W-1:0] addr;
  } ddrmpr_req_t;

  typedef struct packed {
    logic              valid;
    logic              from_array;
    logic [LANE_W-1:0] lower_data_lane;
    logic [LANE_W-1:0] upper_data_lane;
  } ddrmpr_dout_t;

endpackage

//--- ddrmpr_readout.sv
// calibration-register read mode of the sdram command decoder
module ddrmpr_readout (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire ddrmpr_pkg::ddrmpr_req_t req,
  input  wire logic                   copy_lanes,
  output logic                        mode_active,
  output logic                        precharge_req,
  output ddrmpr_pkg::ddrmpr_dout_t    dout
);
  import ddrmpr_pkg::*;

  // ************************************************************
  // mode register state
  // ************************************************************
  logic             en_reg;
  logic [1:0]       loc_reg;
  logic             is_mr3;

  assign is_mr3 = req.valid && req.cmd == DDRMPR_CMD_MRS && req.bank == MR3_SEL;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      en_reg <= 1'b0;
    end else if (is_mr3) begin
      en_reg <= req.addr[MR3_EN_BIT];
    end
  end

  // location kept even with the mode off; it is only consulted while enabled
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      loc_reg <= LOC_PATTERN;
    end else if (is_mr3) begin
      loc_reg <= req.addr[MR3_LOC_MSB:MR3_LOC_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_active <= 1'b0;
    end else begin
      mode_active <= is_mr3 ? req.addr[MR3_EN_BIT] : en_reg;
    end
  end

  // ************************************************************
  // read launch: latency delay then burst
  // ************************************************************
  typedef enum logic [1:0] {DDRMPR_IDLE, DDRMPR_WAIT, DDRMPR_BURST} ddrmpr_state_t;

  ddrmpr_state_t     state_reg;
  logic [LAT_W-1:0]  lat_reg;
  logic [BEAT_W-1:0] beat_reg;
  logic [BEAT_W-1:0] last_reg;
  logic              cal_reg;
  logic [1:0]        rd_loc_reg;
  logic              is_read;
  logic              chop;

  assign is_read = req.valid && (req.cmd == DDRMPR_CMD_RD || req.cmd == DDRMPR_CMD_RDA);
  assign chop    = req.addr[RD_CHOP_BIT];

  logic [BEAT_W-1:0] start_beat;
  logic [BEAT_W-1:0] end_beat;

  // half select only means something for a chopped calibration read
  always_comb begin
    start_beat = BEAT_ZERO;
    end_beat   = BEAT_W'(BURST_LEN - 1);
    if (chop) begin
      if (en_reg && req.addr[RD_HALF_BIT]) begin
        start_beat = HALF_START;
      end else begin
        end_beat = BEAT_W'(CHOP_LEN - 1);
      end
    end
  end

  // a new read during a running burst is dropped; back-to-back reads need tccd spacing upstream
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg  <= DDRMPR_IDLE;
      lat_reg    <= LAT_ZERO;
      beat_reg   <= BEAT_ZERO;
      last_reg   <= BEAT_ZERO;
      cal_reg    <= 1'b0;
      rd_loc_reg <= LOC_PATTERN;
    end else begin
      unique case (state_reg)
        DDRMPR_IDLE: begin
          if (is_read) begin
            state_reg  <= DDRMPR_WAIT;
            lat_reg    <= LAT_W'(READ_LATENCY - 1);
            cal_reg    <= en_reg;
            rd_loc_reg <= loc_reg;
            beat_reg   <= start_beat;
            last_reg   <= end_beat;
          end
        end
        DDRMPR_WAIT: begin
          if (lat_reg == LAT_ZERO) begin
            state_reg <= DDRMPR_BURST;
          end else begin
            lat_reg <= lat_reg - LAT_W'(1);
          end
        end
        DDRMPR_BURST: begin
          if (beat_reg == last_reg) begin
            state_reg <= DDRMPR_IDLE;
          end else begin
            beat_reg <= beat_reg + BEAT_W'(1);
          end
        end
      endcase
    end
  end

  // ************************************************************
  // auto-precharge request to the bank logic
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      precharge_req <= 1'b0;
    end else begin
      precharge_req <= req.valid && req.cmd == DDRMPR_CMD_RDA && !en_reg;
    end
  end

  // ************************************************************
  // data lanes
  // ************************************************************
  logic                 bit_now;
  logic [BURST_LEN-1:0] pat_word;
  logic [LANE_W-1:0]    lower_word;
  logic [LANE_W-1:0]    upper_word;

  always_comb begin
    unique case (rd_loc_reg)
      LOC_PATTERN: begin
        pat_word = CAL_PATTERN;
      end
      default: begin
        // reserved codes have no content; reuse the pattern so lanes stay defined
        pat_word = CAL_PATTERN;
      end
    endcase
  end

  assign bit_now = pat_word[beat_reg];

  ddrmpr_lane_fill #(
    .WIDTH (LANE_W)
  ) u_lower (
    .stream_bit (bit_now),
    .copy_bit   (copy_lanes),
    .cal_sel    (cal_reg),
    .lane_word  (lower_word)
  );

  ddrmpr_lane_fill #(
    .WIDTH (LANE_W)
  ) u_upper (
    .stream_bit (bit_now),
    .copy_bit   (copy_lanes),
    .cal_sel    (cal_reg),
    .lane_word  (upper_word)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dout <= '0;
    end else if (state_reg == DDRMPR_BURST) begin
      dout.valid           <= 1'b1;
      dout.from_array      <= !cal_reg;
      dout.lower_data_lane <= lower_word;
      dout.upper_data_lane <= upper_word;
    end else begin
      dout <= '0;
    end
  end

endmodule // ddrmpr_readout

// ************************************************************
// one data lane: bit 0 carries the stream, upper bits copy or zero
// ************************************************************
// array data is not modelled, so a non-calibration beat drives zero
module ddrmpr_lane_fill #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic        stream_bit,
  input  wire logic        copy_bit,
  input  wire logic        cal_sel,
  output logic [WIDTH-1:0] lane_word
);
  always_comb begin
    lane_word = '0;
    if (cal_sel) begin
      if (copy_bit) begin
        lane_word = {WIDTH{stream_bit}};
      end else begin
        lane_word = {{(WIDTH-1){1'b0}}, stream_bit};
      end
    end
  end
endmodule // ddrmpr_lane_fill

//--- ddrmpr_readout_chk.sv
// port assertions for the readout block
module ddrmpr_readout_chk (
  input wire logic                     mclk,
  input wire logic                     rst_b,
  input wire ddrmpr_pkg::ddrmpr_req_t  req,
  input wire logic                     copy_lanes,
  input wire logic                     mode_active,
  input wire logic                     precharge_req,
  input wire ddrmpr_pkg::ddrmpr_dout_t dout
);
  import ddrmpr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [3:0] bsy_reg;
  wire rd = req.valid && (req.cmd == DDRMPR_CMD_RD || req.cmd == DDRMPR_CMD_RDA);
  wire ok = rd && bsy_reg == 4'h0;
  wire bc4 = req.addr[RD_CHOP_BIT];
  wire mr3 = req.valid && req.cmd == DDRMPR_CMD_MRS && req.bank == MR3_SEL;
  wire [7:0] lo = dout.lower_data_lane;
  // reads inside a burst are dropped, so only taken ones count
  always_ff @(posedge mclk) begin
    if (!rst_b) bsy_reg <= 4'h0;
    else if (bsy_reg != 4'h0) bsy_reg <= bsy_reg - 4'h1;
    else if (rd) bsy_reg <= bc4 ? 4'hA : 4'hE;
  end
  sequence s_lat; ##7 !dout.valid ##1 dout.valid; endsequence
  property p_mode; mr3 |=> mode_active == $past(req.addr[MR3_EN_BIT]); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_rda; rd && mode_active |=> !precharge_req; endproperty
  a_rda: assert property (p_rda) else $error("rda");
  property p_src; ok && mode_active |-> s_lat ##0 (!dout.from_array)[*4]; endproperty
  a_src: assert property (p_src) else $error("src");
  property p_bl8; ok && !bc4 |-> s_lat ##0 dout.valid[*8] ##1 !dout.valid; endproperty
  a_bl8: assert property (p_bl8) else $error("bl8");
  property p_bc4; ok && bc4 |-> s_lat ##0 dout.valid[*4] ##1 !dout.valid; endproperty
  a_bc4: assert property (p_bc4) else $error("bc4");
  property p_lane; dout.valid && !dout.from_array |-> lo == (copy_lanes ? {8{lo[0]}} : {7'h00, lo[0]}); endproperty
  a_lane: assert property (p_lane) else $error("lane");
  property p_up; dout.valid |-> dout.upper_data_lane == lo; endproperty
  a_up: assert property (p_up) else $error("upper");
  property p_rst; disable iff (1'b0) !rst_b |=> !mode_active && !dout.valid && !precharge_req; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule // ddrmpr_readout_chk
bind ddrmpr_readout ddrmpr_readout_chk u_chk (.mclk(mclk), .rst_b(rst_b), .req(req), .copy_lanes(copy_lanes),
  .mode_active(mode_active), .precharge_req(precharge_req), .dout(dout));

//--- ddrmpr_readout_test.sv
// bench for the readout block
module ddrmpr_readout_test;
  timeunit 1ns / 1ps;
  import ddrmpr_pkg::*;
  logic         mclk = 0;
  logic         rst_b = 0;
  logic         copy_lanes = 0;
  logic         mode_active;
  logic         precharge_req;
  ddrmpr_req_t  req;
  ddrmpr_dout_t dout;
  int           mismatches = 0;
  int           compares = 0;
  bit           m;
  logic [16:0]  q[$];
  ddrmpr_ctl_model u_ctl (.mclk(mclk), .req(req));
  ddrmpr_readout u_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .copy_lanes(copy_lanes),
    .mode_active(mode_active), .precharge_req(precharge_req), .dout(dout));
  initial forever #10 mclk = ~mclk;
  task automatic cmp(logic [16:0] g, logic [16:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk) if (dout.valid === 1'b1) cmp({dout.from_array, dout.lower_data_lane, dout.upper_data_lane}, q.pop_front());
  task automatic mrs(bit en);
    u_ctl.send(DDRMPR_CMD_MRS, {11'h000, en, 2'h0});
    m = en;
    cmp(mode_active, en);
    @(posedge mclk);
    #1;
  endtask
  // halves give the same parity, so beat index alone sets the bit
  task automatic rd(bit a, bit c, bit h);
    logic [7:0] l;
    for (int k = 0; k < (c ? 4 : 8); k++) begin
      l = !m ? 8'h00 : copy_lanes ? {8{k[0]}} : {7'h00, k[0]};
      q.push_back({!m, l, l});
    end
    u_ctl.send(a ? DDRMPR_CMD_RDA : DDRMPR_CMD_RD, {1'b0, c, 9'h000, c & h, 2'h0});
    cmp(precharge_req, a && !m);
    repeat (15) @(posedge mclk);
    #1;
  endtask
  initial begin
    void'($urandom(88646));
    repeat (4) @(posedge mclk);
    #1 rst_b = 1;
    repeat (48) begin
      if ($urandom_range(3) == 0) mrs($urandom_range(1));
      copy_lanes = $urandom_range(1);
      rd($urandom_range(1), $urandom_range(1), $urandom_range(1));
    end
    mrs(1);
    rst_b = 0;
    @(posedge mclk);
    #1 rst_b = 1;
    m = 0;
    cmp(mode_active, 1'b0);
    rd(1, 0, 0);
    final_report();
  end
  initial begin
    #50us;
    mismatches++;
    final_report();
  end
endmodule // ddrmpr_readout_test
